// ==== hw/mem_decode_pkg.sv ====
// Constants, target codes and window bases for the memory cycle decoder
package mem_decode_pkg;
    localparam int ADDR_W = 64;
    localparam int PORTS = 20;
    typedef enum logic [3:0] {
        TGT_NONE = 4'h0,
        TGT_FW_LPC = 4'h1,
        TGT_FW_SPI = 4'h2,
        TGT_IOAPIC = 4'h3,
        TGT_PORT_APIC = 4'h4,
        TGT_TIMER = 4'h5,
        TGT_TPM_LPC = 4'h6,
        TGT_TPM_SPI = 4'h7,
        TGT_MGMT = 4'h8,
        TGT_USB3 = 4'h9,
        TGT_UPLINK = 4'hA,
        TGT_LAN = 4'hB,
        TGT_PEER = 4'hC
    } target_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DONE = 2'b01
    } state_e;
    localparam logic [31:0] LEGACY_E_BASE = 32'h000E0000;
    localparam logic [31:0] LEGACY_F_BASE = 32'h000F0000;
    localparam int LEGACY_E_BIT = 6;
    localparam int LEGACY_F_BIT = 7;
    localparam int SEG64K_SHIFT = 16;
    localparam logic [31:0] IOAPIC_BASE = 32'hFEC00000;
    localparam logic [31:0] IOAPIC_LAST = 32'h00000040;
    localparam int SEL_SHIFT = 12;
    localparam logic [31:0] PORT_LO_BASE = 32'hFEC10000;
    localparam logic [31:0] PORT_HI_BASE = 32'hFEC70000;
    localparam int PORT_SHIFT = 15;
    localparam int LO_PORTS = 10;
    localparam int HI_FIRST = 12;
    localparam logic [31:0] FW512_HI_BASE = 32'hFFC00000;
    localparam logic [31:0] FW512_LO_BASE = 32'hFF800000;
    localparam int FW512_SHIFT = 19;
    localparam int FW512_BIT0 = 8;
    localparam int FW512_N = 7;
    localparam logic [31:0] FW_TOP_HI = 32'hFFF80000;
    localparam logic [31:0] FW_TOP_LO = 32'hFFB80000;
    localparam logic [31:0] FW1M_HI_BASE = 32'hFF400000;
    localparam logic [31:0] FW1M_LO_BASE = 32'hFF000000;
    localparam int FW1M_SHIFT = 20;
    localparam int FW1M_N = 4;
    localparam logic [31:0] TIMER_BASE = 32'hFED00000;
    localparam int TIMER_SHIFT = 10;
    localparam logic [31:0] TPM_BASE = 32'hFED40000;
    localparam logic [31:0] MGMT_BASE = 32'hFED50000;
    localparam int USB_SHIFT = 16;
    localparam int SWAP_BIT = 16;
    localparam logic [31:0] TOP_SWAP_BASE = 32'hFFFE0000;
    localparam int TOP_SWAP_SHIFT = 17;
endpackage

// ==== hw/port_apic_match.sv ====
// Per-root-port APIC window match, one generate entry per port
`timescale 1ns/1ps
module port_apic_match
    import mem_decode_pkg::*;
(
    input wire logic [31:0] addr,
    input wire logic [mem_decode_pkg::PORTS-1:0] port_apic_enable,
    output logic hit
);
    import mem_decode_pkg::*;
    logic [PORTS-1:0] hits;
    for (genvar p = 0; p < PORTS; p++)
    begin : g_port
        if (p < LO_PORTS)
        begin : g_lo
            assign hits[p] = port_apic_enable[p] && (addr[31:PORT_SHIFT] ==
                (PORT_LO_BASE[31:PORT_SHIFT] + 17'(p)));
        end
        else if (p >= HI_FIRST)
        begin : g_hi
            assign hits[p] = port_apic_enable[p] && (addr[31:PORT_SHIFT] ==
                (PORT_HI_BASE[31:PORT_SHIFT] + 17'(p - HI_FIRST)));
        end
        else
        begin : g_none
            // Ports 10 and 11 own no window
            assign hits[p] = 1'b0;
        end
    end
    assign hit = |hits;
endmodule // port_apic_match

// ==== hw/memory_cycle_decoder.sv ====
// Memory cycle decoder: steers uplink and external master cycles to targets
// What this block does
// - Uplink cycles no internal target claims are master aborted.
// - External master cycles decode positively except in bridge forwarding windows.
// - Decoded external cycles missing the network controller go up the uplink.
// - E segment goes to firmware only while enable bit 6 is set.
// - F segment goes to firmware only while enable bit 7 is set.
// - I/O APIC claims FECXX000-FECXX040 by range select, when enabled.
// - Each root port except 10 and 11 owns a 32 KB APIC window, gated per port.
// - Enable bits 8 to 14 each open a pair of 512 KB windows.
// - Top 512 KB pair always goes to firmware; top blocks swappable.
// - Enable bits 0 to 3 each open a pair of 1 MB windows.
// - Event timer claims one of four 1 KB windows chosen by config.
// - Trusted window goes to LPC or SPI by strap; FED5 goes to management.
// - USB 3.0 controller claims a 64 KB window anywhere, when enabled.
// - Top swap inverts address bit 16 for the top two 64 KB blocks.
`timescale 1ns/1ps
module memory_cycle_decoder
    import mem_decode_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_from_external,
    input wire logic req_locked,
    input wire logic [mem_decode_pkg::ADDR_W-1:0] req_addr,
    input wire logic [15:0] firmware_decode_enable,
    input wire logic fw_spi_select,
    input wire logic tpm_spi_strap,
    input wire logic [7:0] apic_range_select,
    input wire logic apic_window_enable,
    input wire logic [mem_decode_pkg::PORTS-1:0] port_apic_enable,
    input wire logic [1:0] timer_window_select,
    input wire logic [47:0] usb3_base,
    input wire logic usb3_mem_enable,
    input wire logic [mem_decode_pkg::ADDR_W-1:0] lan_base,
    input wire logic [mem_decode_pkg::ADDR_W-1:0] lan_limit,
    input wire logic [mem_decode_pkg::ADDR_W-1:0] bridge_base,
    input wire logic [mem_decode_pkg::ADDR_W-1:0] bridge_limit,
    input wire logic top_swap_enable,
    output logic rsp_valid,
    output mem_decode_pkg::target_e rsp_target,
    output logic rsp_abort,
    output logic rsp_lock_error,
    output logic [mem_decode_pkg::ADDR_W-1:0] rsp_addr
);
    import mem_decode_pkg::*;

    logic [31:0] a;
    logic hi_zero;
    logic port_hit;
    logic fw_hit, fw_top, internal_hit;
    logic [FW512_N-1:0] fw512_hit;
    logic [FW1M_N-1:0] fw1m_hit;
    target_e fw_tgt;
    target_e tgt_d;
    target_e tgt_q;
    logic abort_d;
    logic [ADDR_W-1:0] addr_d;

    assign a = req_addr[31:0];
    assign hi_zero = (req_addr[ADDR_W-1:32] == 32'h0);
    assign fw_tgt = fw_spi_select ? TGT_FW_SPI : TGT_FW_LPC;

    port_apic_match u_ports (
        .addr(a),
        .port_apic_enable(port_apic_enable),
        .hit(port_hit)
    );

    for (genvar i = 0; i < FW512_N; i++)
    begin : g_fw512
        assign fw512_hit[i] = firmware_decode_enable[FW512_BIT0 + i] &&
            ((a[31:FW512_SHIFT] == (FW512_HI_BASE[31:FW512_SHIFT] + 13'(i))) ||
             (a[31:FW512_SHIFT] == (FW512_LO_BASE[31:FW512_SHIFT] + 13'(i))));
    end
    for (genvar j = 0; j < FW1M_N; j++)
    begin : g_fw1m
        assign fw1m_hit[j] = firmware_decode_enable[j] &&
            ((a[31:FW1M_SHIFT] == (FW1M_HI_BASE[31:FW1M_SHIFT] + 12'(j))) ||
             (a[31:FW1M_SHIFT] == (FW1M_LO_BASE[31:FW1M_SHIFT] + 12'(j))));
    end

    assign fw_top = (a[31:FW512_SHIFT] == FW_TOP_HI[31:FW512_SHIFT]) ||
        (a[31:FW512_SHIFT] == FW_TOP_LO[31:FW512_SHIFT]);
    assign fw_hit = hi_zero && (fw_top || (|fw512_hit) || (|fw1m_hit) ||
        (firmware_decode_enable[LEGACY_E_BIT] &&
         a[31:SEG64K_SHIFT] == LEGACY_E_BASE[31:SEG64K_SHIFT]) ||
        (firmware_decode_enable[LEGACY_F_BIT] &&
         a[31:SEG64K_SHIFT] == LEGACY_F_BASE[31:SEG64K_SHIFT]));

    // Target selection; disabled windows fall through to unclaimed
    always_comb
    begin
        tgt_d = TGT_NONE;
        if (hi_zero && apic_window_enable &&
            a[31:20] == IOAPIC_BASE[31:20] &&
            a[19:SEL_SHIFT] == apic_range_select &&
            a[SEL_SHIFT-1:0] <= IOAPIC_LAST[SEL_SHIFT-1:0])
            tgt_d = TGT_IOAPIC;
        else if (hi_zero && port_hit)
            tgt_d = TGT_PORT_APIC;
        else if (fw_hit)
            tgt_d = fw_tgt;
        else if (hi_zero && a[31:TIMER_SHIFT] ==
                 (TIMER_BASE[31:TIMER_SHIFT] | {20'h0, timer_window_select, 2'h0}))
            tgt_d = TGT_TIMER;
        else if (hi_zero && a[31:PORT_SHIFT] == TPM_BASE[31:PORT_SHIFT])
            tgt_d = tpm_spi_strap ? TGT_TPM_SPI : TGT_TPM_LPC;
        else if (hi_zero && a[31:SEG64K_SHIFT] == MGMT_BASE[31:SEG64K_SHIFT])
            tgt_d = TGT_MGMT;
        else if (usb3_mem_enable && req_addr[ADDR_W-1:USB_SHIFT] == usb3_base)
            tgt_d = TGT_USB3;
    end

    assign internal_hit = (tgt_d != TGT_NONE);

    // External cycles: peer window reserved, LAN claimed, rest up the uplink
    always_comb
    begin
        abort_d = 1'b0;
        if (req_from_external)
        begin
            if (req_addr >= bridge_base && req_addr <= bridge_limit)
                abort_d = 1'b1;
        end
        else
            abort_d = !internal_hit;
    end

    // Swapped address only leaves the block for the top two 64 KB blocks
    always_comb
    begin
        addr_d = req_addr;
        if (top_swap_enable && hi_zero &&
            a[31:TOP_SWAP_SHIFT] == TOP_SWAP_BASE[31:TOP_SWAP_SHIFT])
            addr_d[SWAP_BIT] = ~req_addr[SWAP_BIT];
    end

    // Answer strobe straight from a flop; nothing stalls, so it simply trails the request
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rsp_valid <= 1'b0;
        else
            rsp_valid <= req_valid;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            tgt_q <= TGT_NONE;
        else if (req_valid)
        begin
            if (!req_from_external)
                tgt_q <= tgt_d;
            else if (abort_d)
                tgt_q <= TGT_PEER;
            else if (req_addr >= lan_base && req_addr <= lan_limit)
                tgt_q <= TGT_LAN;
            else
                tgt_q <= TGT_UPLINK;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rsp_abort <= 1'b0;
            rsp_addr <= '0;
            rsp_lock_error <= 1'b0;
        end
        else if (req_valid)
        begin
            rsp_abort <= abort_d;
            rsp_addr <= addr_d;
            // Locks on cycles an internal target decodes are illegal; flag rather than honour them
            rsp_lock_error <= req_locked && internal_hit;
        end
    end

    assign rsp_target = tgt_q;

    uplink_abort_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && !req_from_external && !internal_hit |=> rsp_abort)
        else $error("unclaimed uplink cycle not aborted");
    peer_window_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_from_external && req_addr >= bridge_base &&
        req_addr <= bridge_limit |=> rsp_abort && rsp_target == TGT_PEER)
        else $error("peer window cycle claimed");
    forward_up_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_from_external && !abort_d &&
        !(req_addr >= lan_base && req_addr <= lan_limit) |=> rsp_target == TGT_UPLINK)
        else $error("external cycle not forwarded upstream");
    legacy_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && !req_from_external && req_addr[ADDR_W-1:SEG64K_SHIFT] ==
        48'h0000_0000_000E && !firmware_decode_enable[LEGACY_E_BIT] |=> rsp_abort)
        else $error("E segment claimed while disabled");
    fseg_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && !req_from_external && req_addr[ADDR_W-1:SEG64K_SHIFT] ==
        48'h0000_0000_000F |=> rsp_abort == !$past(firmware_decode_enable[LEGACY_F_BIT]))
        else $error("F segment decode mismatch");
    top_fw_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && !req_from_external && req_addr[ADDR_W-1:FW512_SHIFT] ==
        45'h0000_0000_1FFF |=> rsp_target == TGT_FW_LPC || rsp_target == TGT_FW_SPI)
        else $error("top firmware window not claimed");
    mgmt_route_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && !req_from_external && req_addr[ADDR_W-1:SEG64K_SHIFT] ==
        48'h0000_0000_FED5 |=> rsp_target == TGT_MGMT && !rsp_abort)
        else $error("management window misrouted");
    swap_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && !top_swap_enable |=> rsp_addr == $past(req_addr))
        else $error("address altered with swap disabled");
    // Flag only, never abort: the lock is the requester's fault, the cycle still lands
    lock_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && !req_from_external |=>
        rsp_lock_error == ($past(req_locked) && rsp_target != TGT_NONE))
        else $error("locked uplink cycle flag mismatch");
    rsp_timing_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid |=> rsp_valid ##1 (rsp_valid == $past(req_valid)))
        else $error("answer not one cycle after request");

    ioapic_c: cover property (@(posedge clk) rsp_valid && rsp_target == TGT_IOAPIC);
    port_c: cover property (@(posedge clk) rsp_valid && rsp_target == TGT_PORT_APIC);
    uplink_c: cover property (@(posedge clk) rsp_valid && rsp_target == TGT_UPLINK);
    swap_c: cover property (@(posedge clk) req_valid && top_swap_enable && addr_d != req_addr);
    lock_c: cover property (@(posedge clk) rsp_valid && rsp_lock_error);
endmodule // memory_cycle_decoder

// ==== bench/cycle_source.sv ====
// Request source standing in for the uplink and external masters
`timescale 1ns/1ps
module cycle_source
(
    output logic req_valid,
    output logic req_from_external,
    output logic req_locked,
    output logic [mem_decode_pkg::ADDR_W-1:0] req_addr
);
    import mem_decode_pkg::*;
    initial
    begin
        req_valid = 1'b0;
        req_from_external = 1'b0;
        req_locked = 1'b0;
        req_addr = 64'h0;
    end
    // Request held until the caller moves on; lock state is left as last set
    task automatic send(input logic ext, input logic [63:0] a);
        req_valid = 1'b1;
        req_from_external = ext;
        req_addr = a;
    endtask
    // A lock here breaks the requester's side on purpose, to see it flagged
    task automatic set_lock(input logic l);
        req_locked = l;
    endtask
    // Released address is scrambled so a stale value cannot pass
    task automatic idle();
        req_valid = 1'b0;
        req_addr = ~req_addr;
    endtask
endmodule // cycle_source

// ==== bench/memory_cycle_decoder_tb_top.sv ====
// Self-checking bench for the memory cycle decoder
`timescale 1ns/1ps
module memory_cycle_decoder_tb_top;
    import mem_decode_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid, req_from_external, req_locked;
    logic [63:0] req_addr, rsp_addr;
    logic [15:0] firmware_decode_enable = 16'h0000;
    logic fw_spi_select = 1'b0;
    logic tpm_spi_strap = 1'b0;
    logic [7:0] apic_range_select = 8'h05;
    logic apic_window_enable = 1'b0;
    logic [19:0] port_apic_enable = 20'h00000;
    logic [1:0] timer_window_select = 2'h0;
    logic [47:0] usb3_base = 48'h000000123456;
    logic usb3_mem_enable = 1'b0;
    logic [63:0] lan_base = 64'h90000000;
    logic [63:0] lan_limit = 64'h9000FFFF;
    logic [63:0] bridge_base = 64'h80000000;
    logic [63:0] bridge_limit = 64'h8FFFFFFF;
    logic top_swap_enable = 1'b0;
    logic rsp_valid, rsp_abort, rsp_lock_error;
    target_e rsp_target;
    int mismatches = 0;
    int n_checks = 0;
    cycle_source src (.req_valid, .req_from_external, .req_locked, .req_addr);
    memory_cycle_decoder dut (.clk, .sys_rst, .req_valid, .req_from_external, .req_locked,
        .req_addr, .firmware_decode_enable, .fw_spi_select, .tpm_spi_strap,
        .apic_range_select, .apic_window_enable, .port_apic_enable, .timer_window_select,
        .usb3_base, .usb3_mem_enable, .lan_base, .lan_limit, .bridge_base, .bridge_limit,
        .top_swap_enable, .rsp_valid, .rsp_target, .rsp_abort, .rsp_lock_error, .rsp_addr);
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    task automatic give_verdict();
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One request per call; calls in a row keep valid high, so traffic is back to back
    task automatic go(input logic ext, input logic [63:0] a, input target_e t,
                      input logic [63:0] ea);
        src.send(ext, a);
        @(posedge clk);
        @(negedge clk);
        chk("rsp_valid", rsp_valid, 1'b1);
        chk("rsp_target", rsp_target, t);
        chk("rsp_abort", rsp_abort, t == TGT_NONE || t == TGT_PEER);
        chk("rsp_addr", rsp_addr, ea);
        chk("rsp_lock_error", rsp_lock_error, req_locked && !ext && t != TGT_NONE);
    endtask
    task automatic up(input logic [63:0] a, input target_e t);
        go(1'b0, a, t, a);
    endtask
    task automatic ex(input logic [63:0] a, input target_e t);
        go(1'b1, a, t, a);
    endtask
    function automatic target_e fw();
        return fw_spi_select ? TGT_FW_SPI : TGT_FW_LPC;
    endfunction
    // Bound on the whole run; a hang ends here as a failure
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    initial
    begin
        repeat (2) @(negedge clk);
        chk("rst rsp_valid", rsp_valid, 1'b0);
        chk("rst rsp_target", rsp_target, TGT_NONE);
        chk("rst rsp_abort", rsp_abort, 1'b0);
        chk("rst rsp_addr", rsp_addr, 64'h0);
        chk("rst rsp_lock_error", rsp_lock_error, 1'b0);
        sys_rst = 1'b0;
        up(64'h000E0000, TGT_NONE);
        up(64'h000F0000, TGT_NONE);
        firmware_decode_enable = 16'h00C0;
        up(64'h000EFFFF, fw());
        up(64'h000FFFFF, fw());
        for (int k = 0; k < 7; k++)
        begin
            firmware_decode_enable = 16'h0000;
            up(64'hFFC00000 + k * 64'h80000, TGT_NONE);
            firmware_decode_enable = 16'h0100 << k;
            up(64'hFFC00000 + k * 64'h80000, fw());
            up(64'hFF87FFFF + k * 64'h80000, fw());
        end
        fw_spi_select = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            firmware_decode_enable = 16'h0000;
            up(64'hFF400000 + k * 64'h100000, TGT_NONE);
            firmware_decode_enable = 16'h0001 << k;
            up(64'hFF400000 + k * 64'h100000, fw());
            up(64'hFF0FFFFF + k * 64'h100000, fw());
        end
        firmware_decode_enable = 16'h0000;
        up(64'hFFF80000, fw());
        up(64'hFFBFFFFF, fw());
        top_swap_enable = 1'b1;
        go(1'b0, 64'hFFFF0010, fw(), 64'hFFFE0010);
        go(1'b0, 64'hFFFE0000, fw(), 64'hFFFF0000);
        up(64'hFFFD0000, fw());
        top_swap_enable = 1'b0;
        up(64'hFFFF0000, fw());
        up(64'hFEC05000, TGT_NONE);
        apic_window_enable = 1'b1;
        up(64'hFEC05000, TGT_IOAPIC);
        up(64'hFEC05040, TGT_IOAPIC);
        up(64'hFEC05044, TGT_NONE);
        up(64'hFEC06000, TGT_NONE);
        up(64'hFEC10000, TGT_NONE);
        port_apic_enable = 20'hFFFFF;
        up(64'hFEC10000, TGT_PORT_APIC);
        up(64'hFEC5FFFF, TGT_PORT_APIC);
        up(64'hFEC60000, TGT_NONE);
        up(64'hFEC6FFFF, TGT_NONE);
        up(64'hFEC70000, TGT_PORT_APIC);
        up(64'hFECAFFFF, TGT_PORT_APIC);
        up(64'hFECB0000, TGT_NONE);
        port_apic_enable = 20'hFFFFE;
        up(64'hFEC10000, TGT_NONE);
        up(64'hFEC18000, TGT_PORT_APIC);
        for (int x = 0; x < 4; x++)
        begin
            timer_window_select = x[1:0];
            up(64'hFED00000 + x * 64'h1000, TGT_TIMER);
            up(64'hFED003FF + x * 64'h1000, TGT_TIMER);
            up(64'hFED00400 + x * 64'h1000, TGT_NONE);
            up(64'hFED00000 + ((x + 1) % 4) * 64'h1000, TGT_NONE);
        end
        up(64'hFED40000, TGT_TPM_LPC);
        tpm_spi_strap = 1'b1;
        up(64'hFED47FFF, TGT_TPM_SPI);
        up(64'hFED48000, TGT_NONE);
        up(64'hFED50000, TGT_MGMT);
        up(64'hFED5FFFF, TGT_MGMT);
        up(64'h0000001234560000, TGT_NONE);
        usb3_mem_enable = 1'b1;
        up(64'h0000001234560000, TGT_USB3);
        up(64'h000000123456FFFF, TGT_USB3);
        up(64'h0000001234570000, TGT_NONE);
        up(64'h10000000, TGT_NONE);
        up(64'h00000001FED40000, TGT_NONE);
        up(64'h80000000, TGT_NONE);
        ex(64'h80000000, TGT_PEER);
        ex(64'h8FFFFFFF, TGT_PEER);
        ex(64'h90000000, TGT_LAN);
        ex(64'h9000FFFF, TGT_LAN);
        ex(64'h90010000, TGT_UPLINK);
        ex(64'hFED50000, TGT_UPLINK);
        src.set_lock(1'b1);
        up(64'hFED50000, TGT_MGMT);
        up(64'h10000000, TGT_NONE);
        src.set_lock(1'b0);
        src.idle();
        sys_rst = 1'b1;
        @(negedge clk);
        chk("mid rst rsp_valid", rsp_valid, 1'b0);
        chk("mid rst rsp_abort", rsp_abort, 1'b0);
        chk("mid rst rsp_addr", rsp_addr, 64'h0);
        sys_rst = 1'b0;
        up(64'hFED50000, TGT_MGMT);
        src.idle();
        @(posedge clk);
        @(negedge clk);
        chk("rsp_valid idle", rsp_valid, 1'b0);
        give_verdict();
    end
endmodule // memory_cycle_decoder_tb_top
